// [common/code_phase_map.vh]
`ifndef CODE_PHASE_MAP_VH
`define CODE_PHASE_MAP_VH

// ----------------------------------------------------------------
// Table span and field widths
// ----------------------------------------------------------------
`define PRN_W 8
`define PRN_PRIMARY_LAST 8'h3f
`define PRN_FIRST 8'h40
`define PRN_LAST 8'h63
`define CHIP_COUNT 4'hd
`define CHIP_CNT_W 4
`define STATE_W 13
`define ADV_W 13
`define ENTRY_W 52

// ----------------------------------------------------------------
// Entry layout: {advance I, advance Q, state I, state Q}
// ----------------------------------------------------------------
`define ADV_I_HI 51
`define ADV_I_LO 39
`define ADV_Q_HI 38
`define ADV_Q_LO 26
`define ST_I_HI 25
`define ST_I_LO 13
`define ST_Q_HI 12
`define ST_Q_LO 0

// ----------------------------------------------------------------
// Chip FIFO shape
// ----------------------------------------------------------------
`define FIFO_WIDTH 2
`define FIFO_DEPTH 16
`define FIFO_AW 4

`endif

// [verilog/chip_fifo.v]
`timescale 1ns/1ps
`default_nettype none

module chip_fifo #(
   parameter WIDTH = 2,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire core_clk_in,
   input wire srst_in,
   input wire in_valid_in,
   output wire in_ready_out,
   input wire [WIDTH-1:0] in_data_in,
   output wire out_valid_out,
   input wire out_ready_in,
   output wire [WIDTH-1:0] out_data_out
);

   reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_reg;
   reg [AW-1:0] rd_ptr_reg;
   reg [AW:0] count_reg;
   wire push;
   wire pop;

   // Full and empty come straight from the occupancy count
   assign in_ready_out = (count_reg != DEPTH[AW:0]);
   assign out_valid_out = (count_reg != {(AW+1){1'b0}});
   assign out_data_out = mem_reg[rd_ptr_reg];
   assign push = in_valid_in & in_ready_out;
   assign pop = out_valid_out & out_ready_in;

   always @(posedge core_clk_in) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data_in;
      end
   end

   always @(posedge core_clk_in) begin
      if (srst_in) begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                          wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                          rd_ptr_reg + 1'b1;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// [verilog/spreading_code_phase_table.v]
// What this block does
// - Numbers 1 to 63 belong to the primary code set, so this table's numbering starts above 63.
// - Additional sequences each have their own number, with separate in-phase and quadrature entries.
// - Only entries held in the additional table are ever handed out; other numbers are refused.
// - Each advance is the step count of the second code register from all ones to the start phase.
// - Each initial state is the first 13 second-code chips, bit 0 (rightmost) sent first.
// - The first code register starts at all ones, so the first 13 output chips are the complement.
// - Numbers 64 to 99 each select their own in-phase and quadrature advance and initial state.
// - Number 64 uses advances 7789 and 5246 with states 1000100010001 and 1001101001111.
// - Number 99 uses advances 696 and 4438 with states 1100101001011 and 1000111101101.
`timescale 1ns/1ps
`default_nettype none
`include "code_phase_map.vh"

module spreading_code_phase_table #(
   parameter FIFO_DEPTH = `FIFO_DEPTH,
   parameter FIFO_AW = `FIFO_AW
) (
   input wire core_clk_in,
   input wire srst_in,
   input wire req_valid_in,
   output wire req_ready_out,
   input wire [`PRN_W-1:0] prn_sel_in,
   output reg lookup_done_out,
   output reg prn_refused_out,
   output reg [`ADV_W-1:0] in_phase_code_advance_out,
   output reg [`ADV_W-1:0] quadrature_code_advance_out,
   output reg [`STATE_W-1:0] in_phase_code_state_out,
   output reg [`STATE_W-1:0] quadrature_code_state_out,
   output wire chip_valid_out,
   input wire chip_ready_in,
   output wire in_phase_code_chip_out,
   output wire quadrature_code_chip_out
);

   // ----------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------
   localparam ST_IDLE = 1'b0;
   localparam ST_EMIT = 1'b1;

   reg state_reg;
   reg [`CHIP_CNT_W-1:0] chip_cnt_reg;
   reg [`STATE_W-1:0] shift_i_reg;
   reg [`STATE_W-1:0] shift_q_reg;
   reg [`ENTRY_W-1:0] entry;
   reg entry_hit;
   wire fifo_in_ready;
   wire fifo_push;
   wire [1:0] fifo_out_data;

   // ----------------------------------------------------------------
   // Additional code phase table
   // ----------------------------------------------------------------
   // Primary numbers never reach this table; they map to a miss.
   always @* begin
      entry_hit = 1'b1;
      case (prn_sel_in)
         8'h40: entry = {13'd7789, 13'd5246, 13'b1000100010001, 13'b1001101001111};
         8'h41: entry = {13'd2311, 13'd4259, 13'b0001000101111, 13'b0001100100010};
         8'h42: entry = {13'd7432, 13'd5907, 13'b0001100111111, 13'b0000111111000};
         8'h43: entry = {13'd5155, 13'd3870, 13'b1010101100001, 13'b0011100100111};
         8'h44: entry = {13'd1593, 13'd3262, 13'b0101011111001, 13'b0000001010010};
         8'h45: entry = {13'd5841, 13'd7387, 13'b0101101100001, 13'b1100111111001};
         8'h46: entry = {13'd5014, 13'd3069, 13'b1000101111011, 13'b0111111110010};
         8'h47: entry = {13'd1545, 13'd2999, 13'b0111011001111, 13'b0101011111111};
         8'h48: entry = {13'd3016, 13'd7993, 13'b0001011011000, 13'b1100001111011};
         8'h49: entry = {13'd4875, 13'd7849, 13'b1110000111000, 13'b1110100110101};
         8'h4a: entry = {13'd2119, 13'd4157, 13'b0111010010001, 13'b1010010110101};
         8'h4b: entry = {13'd229, 13'd5031, 13'b0001101111000, 13'b0101111101111};
         8'h4c: entry = {13'd7634, 13'd5986, 13'b1111001010100, 13'b1010110110010};
         8'h4d: entry = {13'd1406, 13'd4833, 13'b1011101110100, 13'b1101110110001};
         8'h4e: entry = {13'd4506, 13'd5739, 13'b0000100110000, 13'b1010000100100};
         8'h4f: entry = {13'd1819, 13'd7846, 13'b1100010000111, 13'b0100110101010};
         8'h50: entry = {13'd7580, 13'd898, 13'b0001101111111, 13'b1000011100011};
         8'h51: entry = {13'd5446, 13'd2022, 13'b1100110101101, 13'b1100111011010};
         8'h52: entry = {13'd6053, 13'd7446, 13'b1101011001011, 13'b0010110001111};
         8'h53: entry = {13'd7958, 13'd6404, 13'b1100001101100, 13'b1101101110110};
         8'h54: entry = {13'd5267, 13'd155, 13'b1011110110001, 13'b1101111001001};
         8'h55: entry = {13'd2956, 13'd7862, 13'b0111010110101, 13'b1100100000000};
         8'h56: entry = {13'd3544, 13'd7795, 13'b1100101101101, 13'b1001101000100};
         8'h57: entry = {13'd1277, 13'd6121, 13'b1100111011111, 13'b1111011010001};
         8'h58: entry = {13'd2996, 13'd4840, 13'b1011111111011, 13'b0110101110111};
         8'h59: entry = {13'd1758, 13'd6585, 13'b1110100100111, 13'b0000100111111};
         8'h5a: entry = {13'd3360, 13'd429, 13'b1111110010100, 13'b1101101001110};
         8'h5b: entry = {13'd2718, 13'd6020, 13'b0101001111110, 13'b1100111001011};
         8'h5c: entry = {13'd3754, 13'd200, 13'b0010100100101, 13'b1010111000011};
         8'h5d: entry = {13'd7440, 13'd1664, 13'b0001111000011, 13'b1110110010110};
         8'h5e: entry = {13'd2781, 13'd1499, 13'b1100111000000, 13'b1110100011111};
         8'h5f: entry = {13'd6756, 13'd7298, 13'b1110010101000, 13'b0001101100011};
         8'h60: entry = {13'd7314, 13'd1305, 13'b0111000101001, 13'b0001011010110};
         8'h61: entry = {13'd208, 13'd7323, 13'b1111101010101, 13'b0000001000111};
         8'h62: entry = {13'd5252, 13'd7544, 13'b1010111001101, 13'b1010011000000};
         8'h63: entry = {13'd696, 13'd4438, 13'b1100101001011, 13'b1000111101101};
         default: begin
            // Primary range and higher numbers held on other sheets are refused
            entry = {`ENTRY_W{1'b0}};
            entry_hit = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Request handshake and chip sequencer
   // ----------------------------------------------------------------
   // A new lookup is held off until all 13 chips of the last one are queued,
   // so the chips of two lookups never interleave in the chip queue.
   assign req_ready_out = (state_reg == ST_IDLE);
   assign fifo_push = (state_reg == ST_EMIT);

   always @(posedge core_clk_in) begin
      if (srst_in) begin
         state_reg <= ST_IDLE;
         chip_cnt_reg <= {`CHIP_CNT_W{1'b0}};
         shift_i_reg <= {`STATE_W{1'b0}};
         shift_q_reg <= {`STATE_W{1'b0}};
         lookup_done_out <= 1'b0;
         prn_refused_out <= 1'b0;
         in_phase_code_advance_out <= {`ADV_W{1'b0}};
         quadrature_code_advance_out <= {`ADV_W{1'b0}};
         in_phase_code_state_out <= {`STATE_W{1'b0}};
         quadrature_code_state_out <= {`STATE_W{1'b0}};
      end else begin
         lookup_done_out <= 1'b0;
         prn_refused_out <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               if (req_valid_in) begin
                  if (entry_hit) begin
                     // Advance and preload state are published as a pair
                     in_phase_code_advance_out <= entry[`ADV_I_HI:`ADV_I_LO];
                     quadrature_code_advance_out <= entry[`ADV_Q_HI:`ADV_Q_LO];
                     in_phase_code_state_out <= entry[`ST_I_HI:`ST_I_LO];
                     quadrature_code_state_out <= entry[`ST_Q_HI:`ST_Q_LO];
                     shift_i_reg <= entry[`ST_I_HI:`ST_I_LO];
                     shift_q_reg <= entry[`ST_Q_HI:`ST_Q_LO];
                     chip_cnt_reg <= {`CHIP_CNT_W{1'b0}};
                     lookup_done_out <= 1'b1;
                     state_reg <= ST_EMIT;
                  end else begin
                     prn_refused_out <= 1'b1;
                  end
               end
            end
            ST_EMIT: begin
               // Stalls here while the chip FIFO is full
               if (fifo_in_ready) begin
                  shift_i_reg <= {1'b0, shift_i_reg[`STATE_W-1:1]};
                  shift_q_reg <= {1'b0, shift_q_reg[`STATE_W-1:1]};
                  if (chip_cnt_reg == `CHIP_COUNT - 4'h1) begin
                     state_reg <= ST_IDLE;
                  end else begin
                     chip_cnt_reg <= chip_cnt_reg + 4'h1;
                  end
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Output chip queue
   // ----------------------------------------------------------------
   // First code register at all ones inverts every leading chip
   chip_fifo #(
      .WIDTH(`FIFO_WIDTH),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) chip_queue (
      .core_clk_in(core_clk_in),
      .srst_in(srst_in),
      .in_valid_in(fifo_push),
      .in_ready_out(fifo_in_ready),
      .in_data_in({~shift_i_reg[0], ~shift_q_reg[0]}),
      .out_valid_out(chip_valid_out),
      .out_ready_in(chip_ready_in),
      .out_data_out(fifo_out_data)
   );

   assign in_phase_code_chip_out = fifo_out_data[1];
   assign quadrature_code_chip_out = fifo_out_data[0];

endmodule

`default_nettype wire

// [bench/spreading_code_phase_table_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module spreading_code_phase_table_chk (
   input wire logic core_clk_in,
   input wire logic srst_in,
   input wire logic req_valid_in,
   input wire logic req_ready_out,
   input wire logic [7:0] prn_sel_in,
   input wire logic lookup_done_out,
   input wire logic prn_refused_out,
   input wire logic [12:0] in_phase_code_advance_out,
   input wire logic [12:0] quadrature_code_advance_out,
   input wire logic [12:0] in_phase_code_state_out,
   input wire logic [12:0] quadrature_code_state_out,
   input wire logic chip_valid_out,
   input wire logic chip_ready_in,
   input wire logic in_phase_code_chip_out,
   input wire logic quadrature_code_chip_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (srst_in);
   wire take = req_valid_in && req_ready_out;
   wire in_rng = prn_sel_in >= 8'h40 && prn_sel_in <= 8'h63;
   wire [51:0] outs = {in_phase_code_advance_out, quadrature_code_advance_out,
      in_phase_code_state_out, quadrature_code_state_out};
   property p_refuse; take && !in_rng |=> prn_refused_out && !lookup_done_out; endproperty
   a_refuse: assert property (p_refuse) else $error("number not refused");
   property p_accept; take && in_rng |=> lookup_done_out && !prn_refused_out; endproperty
   a_accept: assert property (p_accept) else $error("number not accepted");
   property p_quiet; !take |=> !lookup_done_out && !prn_refused_out; endproperty
   a_quiet: assert property (p_quiet) else $error("answer without request");
   property p_first;
      take && prn_sel_in == 8'h40 |=>
         outs == {13'd7789, 13'd5246, 13'b1000100010001, 13'b1001101001111};
   endproperty
   a_first: assert property (p_first) else $error("first entry wrong");
   property p_busy; lookup_done_out |-> !req_ready_out [*8] ##1 !req_ready_out [*5]; endproperty
   a_busy: assert property (p_busy) else $error("ready before 13 chips");
   property p_hold; prn_refused_out |-> $stable(outs); endproperty
   a_hold: assert property (p_hold) else $error("refusal changed outputs");
   property p_head;
      chip_valid_out && !chip_ready_in |=> chip_valid_out &&
         $stable(in_phase_code_chip_out) && $stable(quadrature_code_chip_out);
   endproperty
   a_head: assert property (p_head) else $error("chip head moved");
   property p_chip0;
      lookup_done_out && !chip_valid_out |=> chip_valid_out &&
         in_phase_code_chip_out == !in_phase_code_state_out[0] &&
         quadrature_code_chip_out == !quadrature_code_state_out[0];
   endproperty
   a_chip0: assert property (p_chip0) else $error("first chip wrong");
   c_last: cover property (take && prn_sel_in == 8'h63);
   c_refused: cover property (prn_refused_out);
   c_full: cover property (chip_valid_out && !chip_ready_in && !req_ready_out);
endmodule
bind spreading_code_phase_table spreading_code_phase_table_chk u_chk (
   .core_clk_in(core_clk_in), .srst_in(srst_in), .req_valid_in(req_valid_in),
   .req_ready_out(req_ready_out), .prn_sel_in(prn_sel_in),
   .lookup_done_out(lookup_done_out), .prn_refused_out(prn_refused_out),
   .in_phase_code_advance_out(in_phase_code_advance_out),
   .quadrature_code_advance_out(quadrature_code_advance_out),
   .in_phase_code_state_out(in_phase_code_state_out),
   .quadrature_code_state_out(quadrature_code_state_out),
   .chip_valid_out(chip_valid_out), .chip_ready_in(chip_ready_in),
   .in_phase_code_chip_out(in_phase_code_chip_out),
   .quadrature_code_chip_out(quadrature_code_chip_out));
`default_nettype wire

// [bench/chip_sink.sv]
`timescale 1ns/1ps
`default_nettype none
module chip_sink (
   input wire logic core_clk_in,
   input wire logic srst_in,
   input wire logic clr_in,
   input wire logic stall_in,
   input wire logic slow_in,
   input wire logic chip_valid_in,
   input wire logic i_chip_in,
   input wire logic q_chip_in,
   output logic chip_ready_out,
   output logic [31:0] got_i_out,
   output logic [31:0] got_q_out,
   output logic [5:0] got_n_out
);
   logic tick;
   // Slow mode is ready only every other cycle so the producer has to wait on us
   assign chip_ready_out = !stall_in && (!slow_in || tick);
   always @(posedge core_clk_in) begin
      if (srst_in || clr_in) begin
         tick <= 1'b0;
         got_i_out <= 32'h0;
         got_q_out <= 32'h0;
         got_n_out <= 6'h00;
      end else begin
         tick <= !tick;
         if (chip_valid_in && chip_ready_out) begin
            got_i_out <= {i_chip_in, got_i_out[31:1]};
            got_q_out <= {q_chip_in, got_q_out[31:1]};
            got_n_out <= got_n_out + 6'h01;
         end
      end
   end
endmodule
`default_nettype wire

// [bench/spreading_code_phase_table_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module spreading_code_phase_table_tb_top;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic req_valid = 1'b0;
   logic [7:0] prn = 8'h00;
   logic stall = 1'b0;
   logic slow = 1'b0;
   logic clr = 1'b0;
   wire rdy, done, refused, cvalid, cready, ic, qc;
   wire [12:0] adv_i, adv_q, st_i, st_q;
   wire [31:0] got_i, got_q;
   wire [5:0] got_n;
   int bad_count = 0;
   int comparisons = 0;
   always #20 clk = ~clk;
   spreading_code_phase_table u_spreading_code_phase_table (.core_clk_in(clk),
      .srst_in(srst), .req_valid_in(req_valid), .req_ready_out(rdy), .prn_sel_in(prn),
      .lookup_done_out(done), .prn_refused_out(refused), .in_phase_code_advance_out(adv_i),
      .quadrature_code_advance_out(adv_q), .in_phase_code_state_out(st_i),
      .quadrature_code_state_out(st_q), .chip_valid_out(cvalid), .chip_ready_in(cready),
      .in_phase_code_chip_out(ic), .quadrature_code_chip_out(qc));
   chip_sink u_chip_sink (.core_clk_in(clk), .srst_in(srst), .clr_in(clr), .stall_in(stall),
      .slow_in(slow), .chip_valid_in(cvalid), .i_chip_in(ic), .q_chip_in(qc),
      .chip_ready_out(cready), .got_i_out(got_i), .got_q_out(got_q), .got_n_out(got_n));
   task automatic wrap_up;
      if (bad_count == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input bit ok, input string msg);
      comparisons++;
      if (!ok) begin
         bad_count++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask
   task automatic expire(input int k);
      if (k >= 2000) begin
         chk(1'b0, "wait ran out");
         wrap_up();
      end
   endtask
   task automatic req(input logic [7:0] p);
      int k = 0;
      while (rdy !== 1'b1 && k < 2000) begin
         @(negedge clk);
         k++;
      end
      expire(k);
      req_valid = 1'b1;
      prn = p;
      @(negedge clk);
      req_valid = 1'b0;
   endtask
   task automatic drain(input logic [5:0] n);
      int k = 0;
      while (got_n !== n && k < 2000) begin
         @(negedge clk);
         k++;
      end
      expire(k);
   endtask
   task automatic t_lookup(input logic [7:0] p, input logic [12:0] ai, aq, si, sq);
      clr = 1'b1;
      @(negedge clk);
      clr = 1'b0;
      req(p);
      chk(done === 1'b1 && {adv_i, adv_q, st_i, st_q} === {ai, aq, si, sq}, "values");
      drain(6'd13);
      chk(got_i[31:19] === ~si && got_q[31:19] === ~sq, "chip stream");
   endtask
   task automatic t_refuse;
      logic [7:0] nums [4] = '{8'h00, 8'h3f, 8'h64, 8'hff};
      for (int i = 0; i < 4; i++) begin
         req(nums[i]);
         chk(refused === 1'b1 && done === 1'b0 && adv_i === 13'h0907, "refusal");
         // Let one edge pass so the strobe is not lowered and raised in one step
         @(negedge clk);
      end
   endtask
   task automatic t_fill;
      stall = 1'b1;
      t_lookup_start();
      req(8'h40);
      req(8'h63);
      repeat (30) @(negedge clk);
      chk(rdy === 1'b0 && cvalid === 1'b1 && got_n === 6'd0, "full buffer");
      stall = 1'b0;
      drain(6'd26);
      chk(got_i[31:19] === ~13'h194b && got_i[18:6] === ~13'h1111, "order i");
      chk(got_q[31:19] === ~13'h11ed && got_q[18:6] === ~13'h134f, "order q");
   endtask
   task automatic t_lookup_start;
      clr = 1'b1;
      @(negedge clk);
      clr = 1'b0;
   endtask
   initial begin
      repeat (8) @(negedge clk);
      srst = 1'b0;
      chk(rdy === 1'b1 && cvalid === 1'b0 && adv_i === 13'h0000, "reset state");
      t_lookup(8'h40, 13'h1e6d, 13'h147e, 13'h1111, 13'h134f);
      slow = 1'b1;
      t_lookup(8'h63, 13'h02b8, 13'h1156, 13'h194b, 13'h11ed);
      slow = 1'b0;
      t_lookup(8'h41, 13'h0907, 13'h10a3, 13'h022f, 13'h0322);
      t_refuse();
      t_fill();
      wrap_up();
   end
endmodule
`default_nettype wire
